// File: verilog/port_pins_gpio.sv
// four-pin general purpose port with edge interrupts and two-wire controller override
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "port_pins_defines.svh"

module port_pins_gpio
    import port_pins_pkg::*;
#(
    parameter int unsigned FILT_SAMPLES = `FILTER_SAMPLES
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // apb slave
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pwrite,
    input  wire logic [7:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic            pready,
    output logic [31:0]     prdata,
    output logic            pslverr,
    // port pins
    input  wire logic [7:0] pin_in,
    output logic [7:0]      pin_out,
    output logic [7:0]      pin_oe,
    output logic [7:0]      pin_reduced_drive,
    output logic [7:0]      pin_pull_en,
    output logic [7:0]      pin_pull_up,
    // two-wire controller
    input  wire logic       twc_enable,
    input  wire logic       twc_scl_out,
    input  wire logic       twc_sda_out,
    output logic            twc_scl_in,
    output logic            twc_sda_in,
    // interrupt and wake-up
    output logic            irq,
    output logic            wake
);

    localparam logic [7:0] PMASK = `PIN_MASK;
    localparam logic [7:0] TMASK = `TWC_MASK;
    localparam logic [2:0] FLEN  = 3'(FILT_SAMPLES);

    // registers
    logic [7:0] latch_r;
    logic [7:0] dir_r;
    logic [7:0] drive_r;
    logic [7:0] pull_r;
    logic [7:0] pol_r;
    logic [7:0] ien_r;
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;

    // pin sampling
    logic [7:0] pin_s1_r;
    logic [7:0] pin_s2_r;

    // bus
    reg_sel_t   sel;
    logic       wr_en;
    logic [7:0] wdat;
    logic [7:0] rdat;
    logic       pready_r;
    logic [31:0] prdata_r;
    logic       pslverr_r;

    // pin control
    pin_use_t   use_v [8];
    logic [7:0] out_nxt;
    logic [7:0] oe_nxt;
    logic [7:0] rdr_nxt;
    logic [7:0] pen_nxt;
    logic [7:0] pup_nxt;
    logic [7:0] edge_det;
    logic [7:0] active;

    logic [7:0] out_r;
    logic [7:0] oe_r;
    logic [7:0] rdr_r;
    logic [7:0] pen_r;
    logic [7:0] pup_r;
    logic       scl_in_r;
    logic       sda_in_r;
    logic       irq_r;
    logic       wake_r;

    assign pready            = pready_r;
    assign prdata            = prdata_r;
    assign pslverr           = pslverr_r;
    assign pin_out           = out_r;
    assign pin_oe            = oe_r;
    assign pin_reduced_drive = rdr_r;
    assign pin_pull_en       = pen_r;
    assign pin_pull_up       = pup_r;
    assign twc_scl_in        = scl_in_r;
    assign twc_sda_in        = sda_in_r;
    assign irq               = irq_r;
    assign wake              = wake_r;

    // ---------------- apb decode ----------------
    always_comb begin
        case (paddr)
            8'(`IDX_OUTPUT_LATCH * 4):   sel = SEL_OUTPUT_LATCH;
            8'(`IDX_LEVEL_INPUT * 4):    sel = SEL_LEVEL_INPUT;
            8'(`IDX_DIRECTION * 4):      sel = SEL_DIRECTION;
            8'(`IDX_DRIVE_STRENGTH * 4): sel = SEL_DRIVE_STRENGTH;
            8'(`IDX_PULL_ENABLE * 4):    sel = SEL_PULL_ENABLE;
            8'(`IDX_POLARITY * 4):       sel = SEL_POLARITY;
            8'(`IDX_IRQ_ENABLE * 4):     sel = SEL_IRQ_ENABLE;
            8'(`IDX_IRQ_FLAGS * 4):      sel = SEL_IRQ_FLAGS;
            default:                     sel = SEL_NONE;
        endcase
    end

    // write happens only at the completing edge of the access phase
    assign wr_en = psel && penable && pready_r && pwrite && (sel != SEL_NONE);
    assign wdat  = pwdata[7:0] & PMASK;

    always_comb begin
        case (sel)
            SEL_OUTPUT_LATCH:   rdat = (dir_r & latch_r) | (~dir_r & pin_s2_r);
            SEL_LEVEL_INPUT:    rdat = pin_s2_r;
            SEL_DIRECTION:      rdat = dir_r;
            SEL_DRIVE_STRENGTH: rdat = drive_r;
            SEL_PULL_ENABLE:    rdat = pull_r;
            SEL_POLARITY:       rdat = pol_r;
            SEL_IRQ_ENABLE:     rdat = ien_r;
            SEL_IRQ_FLAGS:      rdat = flags_r;
            default:            rdat = 8'h00;
        endcase
    end

    // one wait-free answer: ready rises for the access cycle after every setup cycle
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= psel && !penable;
            if (psel && !penable) begin
                prdata_r  <= {24'h00_0000, rdat & PMASK};
                pslverr_r <= (sel == SEL_NONE);
            end else begin
                pslverr_r <= 1'b0;
            end
        end
    end

    // ---------------- configuration registers ----------------
    // writes land regardless of pin usage; the pin logic decides what applies
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            latch_r <= `RST_OUTPUT_LATCH;
            dir_r   <= `RST_DIRECTION;
            drive_r <= `RST_DRIVE_STRENGTH;
            pull_r  <= `RST_PULL_ENABLE;
            pol_r   <= `RST_POLARITY;
            ien_r   <= `RST_IRQ_ENABLE;
        end else if (wr_en) begin
            case (sel)
                SEL_OUTPUT_LATCH:   latch_r <= wdat;
                SEL_DIRECTION:      dir_r   <= wdat;
                SEL_DRIVE_STRENGTH: drive_r <= wdat;
                SEL_PULL_ENABLE:    pull_r  <= wdat;
                SEL_POLARITY:       pol_r   <= wdat;
                SEL_IRQ_ENABLE:     ien_r   <= wdat;
                default:            ;
            endcase
        end
    end

    // ---------------- pin sampling ----------------
    // two stages give the allowed two-cycle lag after a direction change
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pin_s1_r <= 8'h00;
            pin_s2_r <= 8'h00;
        end else begin
            pin_s1_r <= pin_in & PMASK;
            pin_s2_r <= pin_s1_r;
        end
    end

    // ---------------- edge filter per pin ----------------
    // active level is the level an edge of the chosen polarity ends on
    assign active = ~(pin_s2_r ^ pol_r);

    for (genvar i = 0; i < 8; i++) begin : g_filt
        if (PMASK[i]) begin : g_on
            logic [2:0] pas_cnt_r;
            logic [2:0] act_cnt_r;
            logic       armed_r;

            // fires on the fourth active sample after four passive ones
            assign edge_det[i] = active[i] && armed_r && (act_cnt_r == FLEN - 3'd1);

            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    pas_cnt_r <= 3'd0;
                    act_cnt_r <= 3'd0;
                    armed_r   <= 1'b0;
                end else if (active[i]) begin
                    pas_cnt_r <= 3'd0;
                    if (act_cnt_r != FLEN) begin
                        act_cnt_r <= act_cnt_r + 3'd1;
                    end
                    if (edge_det[i]) begin
                        armed_r <= 1'b0;
                    end
                end else begin
                    act_cnt_r <= 3'd0;
                    if (pas_cnt_r != FLEN) begin
                        pas_cnt_r <= pas_cnt_r + 3'd1;
                    end
                    if (pas_cnt_r == FLEN - 3'd1) begin
                        armed_r <= 1'b1;
                    end
                end
            end
        end else begin : g_off
            assign edge_det[i] = 1'b0;
        end
    end

    // ---------------- interrupt flags ----------------
    // a detected edge beats a same-cycle clear so no event is lost
    always_comb begin
        flags_nxt = flags_r;
        if (wr_en && sel == SEL_IRQ_FLAGS) begin
            flags_nxt = flags_r & ~wdat;
        end
        flags_nxt = (flags_nxt | edge_det) & PMASK;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            flags_r <= `RST_IRQ_FLAGS;
            irq_r   <= 1'b0;
            wake_r  <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            irq_r   <= |(flags_r & ien_r);
            // held level for the power controller; runs on the bus clock only
            wake_r  <= |(flags_r & ien_r);
        end
    end

    // ---------------- pin usage and drive ----------------
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (TMASK[i] && twc_enable) begin
                use_v[i] = USE_TWC;
            end else if (dir_r[i]) begin
                use_v[i] = USE_GP_OUT;
            end else begin
                use_v[i] = USE_GP_IN;
            end
        end
    end

    always_comb begin
        out_nxt = 8'h00;
        oe_nxt  = 8'h00;
        rdr_nxt = 8'h00;
        pen_nxt = 8'h00;
        pup_nxt = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (PMASK[i]) begin
                case (use_v[i])
                    USE_GP_OUT: begin
                        out_nxt[i] = latch_r[i];
                        oe_nxt[i]  = 1'b1;
                        rdr_nxt[i] = drive_r[i];
                        pen_nxt[i] = 1'b0;
                    end
                    USE_TWC: begin
                        // open drain: only ever pulls low, released otherwise
                        out_nxt[i] = 1'b0;
                        oe_nxt[i]  = (i == `SCL_BIT) ? !twc_scl_out : !twc_sda_out;
                        rdr_nxt[i] = drive_r[i];
                        pen_nxt[i] = pull_r[i] && !pol_r[i];
                        pup_nxt[i] = 1'b1;
                    end
                    default: begin
                        pen_nxt[i] = pull_r[i];
                        pup_nxt[i] = !pol_r[i];
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            out_r    <= 8'h00;
            oe_r     <= 8'h00;
            rdr_r    <= 8'h00;
            pen_r    <= `RST_PULL_ENABLE;
            pup_r    <= `RST_PULL_ENABLE;
            scl_in_r <= 1'b1;
            sda_in_r <= 1'b1;
        end else begin
            out_r    <= out_nxt;
            oe_r     <= oe_nxt;
            rdr_r    <= rdr_nxt;
            pen_r    <= pen_nxt;
            pup_r    <= pup_nxt;
            scl_in_r <= pin_s2_r[`SCL_BIT];
            sda_in_r <= pin_s2_r[`SDA_BIT];
        end
    end

    // ---------------- assertions ----------------
    AST_FLAG_SET: assert property (@(posedge clock) disable iff (sys_rst)
        (edge_det != 8'h00) |=> ((flags_r & $past(edge_det)) == $past(edge_det)))
        else $error("detected edge did not set its flag");

    AST_W1C: assert property (@(posedge clock) disable iff (sys_rst)
        (wr_en && sel == SEL_IRQ_FLAGS && edge_det == 8'h00)
        |=> (flags_r == ($past(flags_r) & ~$past(wdat))))
        else $error("flag write did not clear exactly the ones written");

    AST_IRQ: assert property (@(posedge clock) disable iff (sys_rst)
        ##1 (irq_r == |($past(flags_r) & $past(ien_r))))
        else $error("interrupt does not follow flag and enable");

    AST_WAKE: assert property (@(posedge clock) disable iff (sys_rst)
        ((flags_r & ien_r) != 8'h00) |-> ##1 wake_r)
        else $error("enabled flag did not raise wake");

    AST_RESERVED: assert property (@(posedge clock) disable iff (sys_rst)
        pready_r |-> (prdata_r[5:2] == 4'h0 && prdata_r[31:8] == 24'h00_0000))
        else $error("unimplemented bits read nonzero");

    AST_TWC_OD: assert property (@(posedge clock) disable iff (sys_rst)
        (twc_enable && twc_scl_out && twc_sda_out) |=> (oe_r[7:6] == 2'b00 && out_r[7:6] == 2'b00))
        else $error("controller pins driven while released");

    AST_DIR_KEEP: assert property (@(posedge clock) disable iff (sys_rst)
        (twc_enable && !(wr_en && sel == SEL_DIRECTION)) |=> $stable(dir_r))
        else $error("direction bits changed under controller");

    AST_PULL_PP: assert property (@(posedge clock) disable iff (sys_rst)
        (!twc_enable && dir_r[7]) |=> (!pen_r[7] && oe_r[7] && out_r[7] == $past(latch_r[7])))
        else $error("push-pull output has pull or wrong level");

    AST_LEVEL_RO: assert property (@(posedge clock) disable iff (sys_rst)
        (psel && penable && pready_r && pwrite && sel == SEL_LEVEL_INPUT)
        |=> ($stable(latch_r) && $stable(dir_r) && $stable(pull_r) && $stable(flags_r | 8'h00)
             || $past(edge_det) != 8'h00))
        else $error("write to pin input register changed state");

    AST_FILTER: assert property (@(posedge clock) disable iff (sys_rst)
        edge_det[0] |-> (active[0] && $past(active[0], 1) && $past(active[0], 2)
                         && $past(active[0], 3) && !$past(active[0], 4)))
        else $error("edge accepted without four active samples");

    AST_PULL_INIT: assert property (@(posedge clock)
        $fell(sys_rst) |-> (pull_r == 8'hc3 && pen_r == 8'hc3))
        else $error("pull enables not set out of reset");

    AST_RDR_IN: assert property (@(posedge clock) disable iff (sys_rst)
        !dir_r[1] |=> (rdr_r[1] == 1'b0))
        else $error("reduced drive applied to an input pin");

    AST_IN_UNDRIVEN: assert property (@(posedge clock) disable iff (sys_rst)
        !dir_r[0] |=> (oe_r[0] == 1'b0 && out_r[0] == 1'b0))
        else $error("latch value reached an input pin");

    AST_TWC_PULLUP: assert property (@(posedge clock) disable iff (sys_rst)
        twc_enable |=> (pup_r[7:6] == 2'b11
                        && pen_r[7] == ($past(pull_r[7]) && !$past(pol_r[7]))))
        else $error("controller pin got a pull-down or wrong pull enable");

    AST_TWC_DRIVE: assert property (@(posedge clock) disable iff (sys_rst)
        twc_enable |=> (oe_r[7] == !$past(twc_scl_out)
                        && oe_r[6] == !$past(twc_sda_out)))
        else $error("controller pins not driven from the controller");

endmodule

// File: verilog/port_pins_defines.svh
// register indices, field masks, reset values and timing counts of the four-pin port
`ifndef PORT_PINS_DEFINES_SVH
`define PORT_PINS_DEFINES_SVH

// register indices; the byte address is four times the index
`define IDX_OUTPUT_LATCH   8'h28
`define IDX_LEVEL_INPUT    8'h29
`define IDX_DIRECTION      8'h2a
`define IDX_DRIVE_STRENGTH 8'h2b
`define IDX_PULL_ENABLE    8'h2c
`define IDX_POLARITY       8'h2d
`define IDX_IRQ_ENABLE     8'h2e
`define IDX_IRQ_FLAGS      8'h2f

// implemented pins and pins the two-wire controller can own
`define PIN_MASK           8'hc3
`define TWC_MASK           8'hc0
`define SCL_BIT            7
`define SDA_BIT            6

// reset values
`define RST_OUTPUT_LATCH   8'h00
`define RST_DIRECTION      8'h00
`define RST_DRIVE_STRENGTH 8'h00
`define RST_PULL_ENABLE    8'hc3
`define RST_POLARITY       8'h00
`define RST_IRQ_ENABLE     8'h00
`define RST_IRQ_FLAGS      8'h00

// edge filter: samples of each level needed for a valid edge
`define FILTER_SAMPLES     4

`endif

// File: verilog/port_pins_pkg.sv
// types shared by the four-pin port
package port_pins_pkg;

    typedef enum logic [1:0] {
        USE_GP_IN  = 2'b00,
        USE_GP_OUT = 2'b01,
        USE_TWC    = 2'b10
    } pin_use_t;

    typedef enum logic [3:0] {
        SEL_OUTPUT_LATCH   = 4'b0000,
        SEL_LEVEL_INPUT    = 4'b0001,
        SEL_DIRECTION      = 4'b0010,
        SEL_DRIVE_STRENGTH = 4'b0011,
        SEL_PULL_ENABLE    = 4'b0100,
        SEL_POLARITY       = 4'b0101,
        SEL_IRQ_ENABLE     = 4'b0110,
        SEL_IRQ_FLAGS      = 4'b0111,
        SEL_NONE           = 4'b1111
    } reg_sel_t;

endpackage

// File: verification/port_pins_far_end.sv
// far side of the port: pin wires with external drivers and pull devices
`timescale 1ns/10ps

module port_pins_far_end (
    // clock
    input  wire logic       clock,
    // device side of each pin
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_pull_en,
    input  wire logic [7:0] pin_pull_up,
    // external drivers
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    // resolved pin levels
    output logic [7:0]      pin_in
);
    logic [7:0] float_r = 8'h55;

    // a floating wire keeps changing so nothing leans on a settled unknown
    always @(posedge clock) begin
        float_r <= ~float_r;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pin_pull_en[i])
                pin_in[i] = pin_pull_up[i];
            else
                pin_in[i] = float_r[i];
        end
    end
endmodule

// File: verification/test_port_pins_gpio.sv
// self-checking bench of the four-pin port against a register-level model
`timescale 1ns/10ps
`include "port_pins_defines.svh"

module test_port_pins_gpio
    import port_pins_pkg::*;
;
    logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, pin_in, pin_out, pin_oe, pin_reduced_drive, pin_pull_en, pin_pull_up;
    logic [7:0]  ext_val, ext_en;
    logic [31:0] pwdata, prdata;
    logic        twc_enable, twc_scl_out, twc_sda_out, twc_scl_in, twc_sda_in, irq, wake;
    int          n_mismatch, samples_checked, seed, m_lvl;
    int          m_reg[8];

    port_pins_gpio #(.FILT_SAMPLES(4)) i_port_pins_gpio (
        .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_reduced_drive(pin_reduced_drive), .pin_pull_en(pin_pull_en),
        .pin_pull_up(pin_pull_up), .twc_enable(twc_enable), .twc_scl_out(twc_scl_out),
        .twc_sda_out(twc_sda_out), .twc_scl_in(twc_scl_in), .twc_sda_in(twc_sda_in),
        .irq(irq), .wake(wake));

    port_pins_far_end i_port_pins_far_end (
        .clock(clock), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en),
        .pin_pull_up(pin_pull_up), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // entered just after a rising edge; leaves one idle cycle behind it
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx[5:0], 2'b00};
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        // no wait count of its own: a slave that never answers runs into the watchdog
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, idx, d, rd, err);
        chk(err, 32'(idx > `IDX_IRQ_FLAGS));
        if (idx == `IDX_IRQ_FLAGS)
            m_reg[7] = m_reg[7] & ~d;
        else if (idx != `IDX_LEVEL_INPUT)
            m_reg[idx - 8'h28] = d & 8'hc3;
    endtask

    // lets every pending edge through the filter, then clears all flags
    task automatic settle();
        repeat (12) @(posedge clock);
        wr(`IDX_IRQ_FLAGS, 32'hff);
    endtask

    function automatic int exp_read(input logic [7:0] idx);
        if (idx == `IDX_OUTPUT_LATCH)
            return (m_reg[2] & m_reg[0] | ~m_reg[2] & m_lvl) & 8'hc3;
        if (idx == `IDX_LEVEL_INPUT)
            return m_lvl & 8'hc3;
        return (idx <= `IDX_IRQ_FLAGS) ? m_reg[idx - 8'h28] : 0;
    endfunction

    task automatic rd_chk(input logic [7:0] idx);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, idx, 32'h0, rd, err);
        chk(rd, exp_read(idx));
        chk(err, 32'(idx > `IDX_IRQ_FLAGS));
    endtask

    task automatic check_all();
        int own, dir, oe, out, rdr, pe, pu;
        repeat (4) @(posedge clock);
        own = twc_enable ? 8'hc0 : 8'h00;
        dir = m_reg[2] & ~own;
        oe = (dir | own & {~twc_scl_out, ~twc_sda_out, 6'h00}) & 8'hc3;
        out = dir & m_reg[0];
        rdr = oe & m_reg[3] & ~own;
        pe = m_reg[4] & ~dir & ~(own & m_reg[5]) & 8'hc3;
        pu = ~m_reg[5] | own;
        m_lvl = oe & out | ~oe & ext_en & ext_val | ~oe & ~ext_en & pe & pu;
        chk(pin_oe, oe);
        chk(pin_out & pin_oe, out & oe);
        chk(pin_reduced_drive & ~own[7:0], rdr);
        chk(pin_pull_en, pe);
        chk(pin_pull_up & pin_pull_en, pu & pe);
        chk({twc_scl_in, twc_sda_in}, m_lvl[7:6]);
        chk(irq, 32'((m_reg[6] & m_reg[7]) != 0));
        chk(wake, 32'((m_reg[6] & m_reg[7]) != 0));
        for (int i = 0; i < 9; i++)
            rd_chk(8'h28 + 8'(i));
    endtask

    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        m_reg = '{0, 0, 0, 0, 8'hc3, 0, 0, 0};
        @(posedge clock);
    endtask

    initial begin
        repeat (60000) @(posedge clock);
        n_mismatch++;
        stop_test();
    end

    initial begin
        seed = 9673;
        sys_rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {twc_enable, twc_scl_out, twc_sda_out} = 3'b011;
        ext_val = 8'hff;
        ext_en = 8'h00;
        do_reset();
        check_all();
        ext_en <= 8'hff;
        // arbitrary settings, writes to the input register among them
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 7; i++)
                wr(8'h28 + 8'(i), $random(seed));
            ext_val <= 8'($random(seed));
            {twc_enable, twc_scl_out, twc_sda_out} <= 3'($random(seed));
            settle();
            check_all();
        end
        // controller takes pins 7 and 6 while direction bits stay stored
        wr(`IDX_DIRECTION, 32'hc3);
        wr(`IDX_PULL_ENABLE, 32'hc3);
        wr(`IDX_POLARITY, 32'h80);
        twc_enable <= 1'b1;
        twc_scl_out <= 1'b0;
        twc_sda_out <= 1'b1;
        // handing pins over can make edges the model does not track
        settle();
        check_all();
        twc_enable <= 1'b0;
        settle();
        check_all();
        // edges: pin 0 rising, others falling
        ext_val <= 8'hc2;
        wr(`IDX_DIRECTION, 32'h00);
        wr(`IDX_POLARITY, 32'h01);
        wr(`IDX_IRQ_ENABLE, 32'hc3);
        repeat (12) @(posedge clock);
        wr(`IDX_IRQ_FLAGS, 32'hff);
        ext_val <= 8'h80;
        repeat (3) @(posedge clock);
        ext_val <= 8'h82;
        @(posedge clock);
        ext_val <= 8'hc2;
        repeat (12) @(posedge clock);
        m_reg[7] = 8'h40;
        check_all();
        wr(`IDX_IRQ_FLAGS, 32'h40);
        ext_val <= 8'h43;
        repeat (12) @(posedge clock);
        m_reg[7] = m_reg[7] | 8'h81;
        check_all();
        wr(`IDX_IRQ_FLAGS, 32'h00);
        wr(`IDX_IRQ_FLAGS, 32'h01);
        wr(`IDX_IRQ_ENABLE, 32'h01);
        check_all();
        // reset again in mid-run
        ext_en <= 8'h00;
        do_reset();
        check_all();
        stop_test();
    end
endmodule
